// file: can_msg_store_pkg.sv
// Constants and carriers for the CAN message buffer storage
package can_msg_store_pkg;

  localparam logic [15:0] WINDOW_BASE = 16'h0100;
  localparam int WINDOW_LSB = 7;

  localparam int NUM_TX = 3;
  localparam int NUM_BUFS = 4;
  localparam int MSG_BYTES = 14;
  localparam int NUM_ID_BYTES = 4;
  localparam int MAX_DATA = 8;

  localparam logic [3:0] OFF_DATA = 4'h4;
  localparam logic [3:0] OFF_DLR = 4'hC;
  localparam logic [3:0] OFF_PRIO = 4'hD;

  localparam logic [2:0] SLOT_BG = 3'h2;
  localparam logic [1:0] BUF_FG = 2'h0;
  localparam logic [1:0] BUF_TX0 = 2'h1;

  localparam logic [7:0] DLC_MASK = 8'h0F;
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam logic [3:0] DLC_NONE = 4'h0;

  localparam int B1_SRR = 4;
  localparam int B1_IDE = 3;
  localparam int B1_STD_RTR = 4;
  localparam int B3_EXT_RTR = 0;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic [3:0] index;
    byte_t data;
  } rx_byte_s;

  typedef struct packed {
    logic [28:0] identifier;
    logic extended;
    logic remote;
    logic substRemote;
    logic [3:0] lengthCode;
  } tx_header_s;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

endpackage

// file: can_message_buffer_storage.sv
// Receive and transmit message buffers with CPU window and send path
//
// Overview of operation
// - Decode one 128-byte window in CPU space
// - Background buffer readable only in test mode
// - Buffer slots: nibble 4 receive, 5-7 transmit
// - Sixteen locations per buffer, same layout
// - Id 0-3, data 4-B, length C, priority D
// - Message bytes are not reset
// - Foreground buffer readable, writes ignored
// - Transmit buffers readable and writable anytime
// - Extended identifier bit placement in four bytes
// - Standard identifier bit placement in two bytes
// - Identifier MSB first, smallest value wins
// - Substitute remote bit stored as received
// - Extension flag selects 11 or 29 bits
// - Remote bit: 0 data, 1 remote
// - Length code in low nibble, 0 to 8
// - Remote frame sends length, no data
// - Bytes moved follow the length code
// - Full transmit buffers compete, lowest priority wins
// - Equal priority: lower index wins
`timescale 1ns/1ns
`default_nettype none

module can_message_buffer_storage
  import can_msg_store_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData_q,
  input wire logic testMode,
  input wire logic rxWrite,
  input wire rx_byte_s rxByte,
  input wire logic rxCopy,
  input wire logic [NUM_TX-1:0] txEmpty,
  input wire logic txArbitrate,
  input wire logic txDataReady,
  output logic txStart_q,
  output logic [1:0] txWinner_q,
  output tx_header_s txHeader_q,
  output logic [7:0] txData_q,
  output logic txDataValid_q,
  output logic txDone_q
);

  // Message storage has no reset on purpose
  byte_t msgMem_q [NUM_BUFS][MSG_BYTES];
  byte_t bgMem_q [MSG_BYTES];

  logic winHit;
  logic [2:0] slot;
  logic [1:0] bufIdx;
  logic [3:0] regIdx;
  logic msgHit;
  logic regInLayout;
  logic cpuTxWrite;
  logic [7:0] rdValue;

  function automatic tx_header_s decodeHeader(input byte_t b0, input byte_t b1,
                                              input byte_t b2, input byte_t b3,
                                              input byte_t frame_length_code);
    tx_header_s h;
    h.extended = b1[B1_IDE];
    if (b1[B1_IDE]) begin
      h.identifier = {b0, b1[7:5], b1[2:0], b2, b3[7:1]};
      h.remote = b3[B3_EXT_RTR];
      h.substRemote = b1[B1_SRR];
    end else begin
      h.identifier = {18'h0_0000, b0, b1[7:5]};
      h.remote = b1[B1_STD_RTR];
      h.substRemote = 1'b0;
    end
    h.lengthCode = frame_length_code[3:0];
    return h;
  endfunction

  function automatic logic [3:0] byteCount(input tx_header_s h);
    logic [3:0] n;
    if (h.remote) begin
      n = DLC_NONE;
    end else if (h.lengthCode > DLC_MAX) begin
      n = DLC_MAX;
    end else begin
      n = h.lengthCode;
    end
    return n;
  endfunction

  assign winHit = busAddr[15:WINDOW_LSB] == WINDOW_BASE[15:WINDOW_LSB];
  assign slot = busAddr[6:4];
  assign bufIdx = slot[1:0];
  assign regIdx = busAddr[3:0];
  assign msgHit = winHit && slot[2];
  assign regInLayout = regIdx <= OFF_PRIO;
  assign cpuTxWrite = wrStrobe && msgHit && bufIdx != BUF_FG && regInLayout;

  // Read path
  always_comb begin
    rdValue = 8'h00;
    if (msgHit && regInLayout) begin
      if (!(bufIdx == BUF_FG && regIdx == OFF_PRIO)) begin
        rdValue = msgMem_q[bufIdx][regIdx];
      end
    end else if (winHit && slot == SLOT_BG && testMode && regIdx < OFF_PRIO) begin
      rdValue = bgMem_q[regIdx];
    end
    if (regIdx == OFF_DLR) begin
      rdValue = rdValue & DLC_MASK;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdData_q <= 8'h00;
    end else if (rdStrobe) begin
      rdData_q <= rdValue;
    end else begin
      rdData_q <= 8'h00;
    end
  end

  // Background buffer, filled by the receive engine
  always_ff @(posedge clock) begin
    if (rxWrite && rxByte.index < OFF_PRIO) begin
      bgMem_q[rxByte.index] <= rxByte.data;
    end
  end

  tx_header_s rxHeader;
  logic [3:0] rxCount;
  assign rxHeader = decodeHeader(bgMem_q[0], bgMem_q[1], bgMem_q[2], bgMem_q[3],
                                 bgMem_q[OFF_DLR]);
  assign rxCount = byteCount(rxHeader);

  // Foreground copy and CPU writes share one writer
  always_ff @(posedge clock) begin
    if (rxCopy) begin
      for (int i = 0; i < NUM_ID_BYTES; i++) begin
        msgMem_q[BUF_FG][i] <= bgMem_q[i];
      end
      msgMem_q[BUF_FG][OFF_DLR] <= bgMem_q[OFF_DLR] & DLC_MASK;
      for (int i = 0; i < MAX_DATA; i++) begin
        if (i < int'(rxCount)) begin
          msgMem_q[BUF_FG][int'(OFF_DATA) + i] <= bgMem_q[int'(OFF_DATA) + i];
        end
      end
    end
    if (cpuTxWrite) begin
      if (regIdx == OFF_DLR) begin
        msgMem_q[bufIdx][regIdx] <= wrData & DLC_MASK;
      end else begin
        msgMem_q[bufIdx][regIdx] <= wrData;
      end
    end
  end

  // Arbitration among full transmit buffers
  logic winFound;
  logic [1:0] winIdx;
  byte_t winPrio;

  always_comb begin
    winFound = 1'b0;
    winIdx = 2'h0;
    winPrio = 8'h00;
    for (int i = 0; i < NUM_TX; i++) begin
      // Strict less-than keeps the earlier, lower index on a tie
      if (!txEmpty[i] && (!winFound || msgMem_q[i + 1][OFF_PRIO] < winPrio)) begin
        winFound = 1'b1;
        winIdx = 2'(i);
        winPrio = msgMem_q[i + 1][OFF_PRIO];
      end
    end
  end

  tx_header_s winHeader;
  logic [1:0] winBuf;
  assign winBuf = winIdx + BUF_TX0;
  assign winHeader = decodeHeader(msgMem_q[winBuf][0], msgMem_q[winBuf][1],
                                  msgMem_q[winBuf][2], msgMem_q[winBuf][3],
                                  msgMem_q[winBuf][OFF_DLR]);

  // Send sequencer
  tx_state_e txState_q;
  logic [3:0] txLeft_q;
  logic [3:0] txPos_q;
  logic [1:0] txBuf;
  assign txBuf = txWinner_q + BUF_TX0;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txState_q <= TX_IDLE;
      txStart_q <= 1'b0;
      txDone_q <= 1'b0;
      txWinner_q <= 2'h0;
      txHeader_q <= '0;
      txLeft_q <= 4'h0;
      txPos_q <= 4'h0;
      txData_q <= 8'h00;
      txDataValid_q <= 1'b0;
    end else begin
      txStart_q <= 1'b0;
      txDone_q <= 1'b0;
      unique case (txState_q)
        TX_IDLE: begin
          if (txArbitrate && winFound) begin
            txState_q <= TX_SEND;
            txStart_q <= 1'b1;
            txWinner_q <= winIdx;
            // Standard identifier sits right-justified in the low 11 bits, upper 18 bits zero
            txHeader_q <= winHeader;
            txLeft_q <= byteCount(winHeader);
            txPos_q <= 4'h0;
          end
        end
        TX_SEND: begin
          if (txDataValid_q) begin
            if (txDataReady) begin
              txDataValid_q <= 1'b0;
              txLeft_q <= txLeft_q - 4'h1;
              txPos_q <= txPos_q + 4'h1;
            end
          end else if (txLeft_q != 4'h0) begin
            // Data is read live; stable only if software keeps off it
            txData_q <= msgMem_q[txBuf][OFF_DATA + txPos_q];
            txDataValid_q <= 1'b1;
          end else begin
            txDone_q <= 1'b1;
            txState_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Assertion helpers
  logic [3:0] sentCount_q;
  logic allPrioEqual;
  logic fgByte0Wr;
  logic tx0Byte0Wr;
  byte_t fgByte0;
  byte_t tx0Byte0;

  assign allPrioEqual = msgMem_q[1][OFF_PRIO] == msgMem_q[2][OFF_PRIO] &&
                        msgMem_q[2][OFF_PRIO] == msgMem_q[3][OFF_PRIO];
  assign fgByte0Wr = wrStrobe && msgHit && bufIdx == BUF_FG && regIdx == 4'h0;
  assign tx0Byte0Wr = wrStrobe && msgHit && bufIdx == BUF_TX0 && regIdx == 4'h0;
  assign fgByte0 = msgMem_q[BUF_FG][0];
  assign tx0Byte0 = msgMem_q[BUF_TX0][0];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sentCount_q <= 4'h0;
    end else if (txStart_q) begin
      sentCount_q <= 4'h0;
    end else if (txDataValid_q && txDataReady) begin
      sentCount_q <= sentCount_q + 4'h1;
    end
  end

  property p_out_of_window;
    @(posedge clock) disable iff (reset)
      (rdStrobe && !winHit) |=> (rdData_q == 8'h00);
  endproperty
  a_out_of_window: assert property (p_out_of_window)
    else $error("read outside window returned data");

  property p_bg_hidden;
    @(posedge clock) disable iff (reset)
      (rdStrobe && winHit && slot == SLOT_BG && !testMode) |=> (rdData_q == 8'h00);
  endproperty
  a_bg_hidden: assert property (p_bg_hidden)
    else $error("background buffer visible outside test mode");

  property p_fg_read_only;
    @(posedge clock) disable iff (reset)
      (fgByte0Wr && !rxCopy) |=> $stable(fgByte0);
  endproperty
  a_fg_read_only: assert property (p_fg_read_only)
    else $error("write changed foreground buffer");

  property p_tx_write;
    @(posedge clock) disable iff (reset)
      tx0Byte0Wr |=> (tx0Byte0 == $past(wrData));
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("transmit buffer write not stored");

  property p_unused_zero;
    @(posedge clock) disable iff (reset)
      (rdStrobe && msgHit && regIdx > OFF_PRIO) |=> (rdData_q == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused offset read nonzero");

  property p_dlr_high_zero;
    @(posedge clock) disable iff (reset)
      (rdStrobe && regIdx == OFF_DLR) |=> (rdData_q[7:4] == 4'h0);
  endproperty
  a_dlr_high_zero: assert property (p_dlr_high_zero)
    else $error("length register high bits nonzero");

  property p_winner_full;
    @(posedge clock) disable iff (reset)
      txStart_q |-> !$past(txEmpty[winIdx]);
  endproperty
  a_winner_full: assert property (p_winner_full)
    else $error("empty buffer won arbitration");

  property p_tie_low_index;
    @(posedge clock) disable iff (reset)
      (txStart_q && $past(txEmpty) == 3'h0 && $past(allPrioEqual)) |-> (txWinner_q == 2'h0);
  endproperty
  a_tie_low_index: assert property (p_tie_low_index)
    else $error("tie not resolved to lowest index");

  property p_remote_no_data;
    @(posedge clock) disable iff (reset)
      (txStart_q && txHeader_q.remote) |-> (!txDataValid_q ##1 (!txDataValid_q && txDone_q));
  endproperty
  a_remote_no_data: assert property (p_remote_no_data)
    else $error("remote frame sent data bytes");

  property p_byte_count;
    @(posedge clock) disable iff (reset)
      txDone_q |-> (sentCount_q == byteCount(txHeader_q));
  endproperty
  a_byte_count: assert property (p_byte_count)
    else $error("sent byte count differs from length code");

  property p_done_bound;
    @(posedge clock) disable iff (reset)
      txStart_q |-> ##[1:40] txDone_q;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("send did not finish");

  property p_rd_idle_zero;
    @(posedge clock) disable iff (reset)
      !rdStrobe |=> (rdData_q == 8'h00);
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data present without a read");

  property p_copy_length;
    @(posedge clock) disable iff (reset)
      rxCopy |=> (msgMem_q[BUF_FG][OFF_DLR] == ($past(bgMem_q[OFF_DLR]) & DLC_MASK));
  endproperty
  a_copy_length: assert property (p_copy_length)
    else $error("copied length code differs from received");

  property p_data_hold;
    @(posedge clock) disable iff (reset)
      (txDataValid_q && !txDataReady) |=> (txDataValid_q && $stable(txData_q));
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("payload byte dropped before handshake");

  property p_refused_start;
    @(posedge clock) disable iff (reset)
      (txArbitrate && &txEmpty) |=> !txStart_q;
  endproperty
  a_refused_start: assert property (p_refused_start)
    else $error("start with all transmit buffers empty");

  c_tx_data: cover property (@(posedge clock) txStart_q ##[1:20] txDataValid_q && txDataReady);
  c_rx_copy: cover property (@(posedge clock) rxCopy ##1 rdStrobe && msgHit);
  c_bg_read: cover property (@(posedge clock) rdStrobe && slot == SLOT_BG && testMode);
  c_tie: cover property (@(posedge clock) txArbitrate && txEmpty == 3'h0 && allPrioEqual);

endmodule

`default_nettype wire

// file: can_engine_model.sv
// Transmit engine stand-in that takes payload bytes at a chosen pace
`timescale 1ns/1ns
`default_nettype none
module can_engine_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic slow,
  input wire logic txDataValid_q,
  output logic txDataReady
);
  logic [1:0] pace_q;
  // Slow pace takes a byte only every third cycle to stretch the handshake
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pace_q <= 2'h0;
    end else begin
      pace_q <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
    end
  end
  assign txDataReady = txDataValid_q && (!slow || pace_q == 2'h2);
endmodule
`default_nettype wire

// file: can_message_buffer_storage_tb.sv
// Self-checking bench for the CAN message buffer storage
`timescale 1ns/1ns
`default_nettype none
module can_message_buffer_storage_tb
  import can_msg_store_pkg::*;
;
  logic clock, reset, wrStrobe, rdStrobe, testMode, rxWrite, rxCopy, txArbitrate;
  logic slow, rdLate, txDataReady, txStart_q, txDataValid_q, txDone_q;
  logic [15:0] busAddr;
  logic [7:0] wrData, rdData_q, txData_q, seed;
  logic [2:0] txEmpty;
  logic [1:0] txWinner_q;
  rx_byte_s rxByte;
  tx_header_s txHeader_q, extHdr;
  logic [36:0] expQ[$];
  byte_t shadow[3][16];
  byte_t bg[13];
  byte_t fg[16];
  logic [23:0] setup[11] = '{24'h01_60A5, 24'h01_61A0, 24'h01_6C02, 24'h01_6D03, 24'h01_7D03,
    24'h01_5D05, 24'h01_5012, 24'h01_517D, 24'h01_529A, 24'h01_5357, 24'h01_5C05};
  int error_cnt = 0;
  int checked = 0;

  can_message_buffer_storage i_can_message_buffer_storage (.clock(clock), .reset(reset),
    .busAddr(busAddr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData_q(rdData_q), .testMode(testMode), .rxWrite(rxWrite), .rxByte(rxByte),
    .rxCopy(rxCopy), .txEmpty(txEmpty), .txArbitrate(txArbitrate),
    .txDataReady(txDataReady), .txStart_q(txStart_q), .txWinner_q(txWinner_q),
    .txHeader_q(txHeader_q), .txData_q(txData_q), .txDataValid_q(txDataValid_q),
    .txDone_q(txDone_q));
  can_engine_model i_can_engine_model (.clock(clock), .reset(reset), .slow(slow),
    .txDataValid_q(txDataValid_q), .txDataReady(txDataReady));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic byte_t lfsr(input byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Receive buffer has no priority byte, so its offset D reads zero too
  function automatic byte_t expByte(input byte_t v, input int o, input bit rx);
    return (o > (rx ? 12 : 13)) ? 8'h00 : (o == 12) ? (v & 8'h0F) : v;
  endfunction

  task automatic check(input logic [36:0] got, input logic [36:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [15:0] a, input byte_t d);
    wrStrobe <= w;
    rdStrobe <= r;
    busAddr <= a;
    wrData <= d;
    @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] a, input byte_t d);
    bus(1'b1, 1'b0, a, d);
    if (a[7:4] >= 4'h5 && a[7:4] <= 4'h7) shadow[a[5:4] - 2'h1][a[3:0]] = d;
  endtask

  task automatic rd(input logic [15:0] a, input byte_t e);
    bus(1'b0, 1'b1, a, 8'h00);
    expQ.push_back({29'h0, e});
  endtask

  task automatic send(input logic [2:0] empty, input logic [1:0] w, input tx_header_s h,
                      input int n);
    int i;
    // Drop any strobe left high by the last bus call
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
    expQ.push_back(h);
    expQ.push_back({35'h0, w});
    for (i = 0; i < n; i++) expQ.push_back({29'h0, shadow[w][4 + i]});
    txEmpty <= empty;
    txArbitrate <= 1'b1;
    @(posedge clock);
    txArbitrate <= 1'b0;
    for (i = 0; i < 200 && txDone_q !== 1'b1; i++) @(negedge clock);
    check({36'h0, txDone_q}, 37'h1, "done");
    check(37'(expQ.size()), 37'h0, "missing bytes");
    @(posedge clock);
    txEmpty <= 3'b111;
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock) rdLate <= rdStrobe;

  always @(negedge clock) begin
    if ((rdLate || txStart_q || (txDataValid_q && txDataReady)) && expQ.size() == 0) begin
      error_cnt++;
      $display("wrong value at %0t: output with nothing expected", $time);
    end else if (txStart_q) begin
      check(txHeader_q, expQ.pop_front(), "header");
      check({35'h0, txWinner_q}, expQ.pop_front(), "winner");
    end else if (txDataValid_q && txDataReady) begin
      check({29'h0, txData_q}, expQ.pop_front(), "payload");
    end else if (rdLate) begin
      check({29'h0, rdData_q}, expQ.pop_front(), "read");
    end
  end

  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  initial begin
    int b, o, k;
    reset = 1'b1;
    {wrStrobe, rdStrobe, testMode, rxWrite, rxCopy, txArbitrate, slow} = 7'h00;
    busAddr = 16'h0000;
    wrData = 8'h00;
    rxByte = '0;
    txEmpty = 3'b111;
    seed = 8'h52;
    extHdr = {8'h12, 3'b011, 3'b101, 8'h9A, 7'h2B, 1'b1, 1'b1, 1'b1, 4'h5};
    fg = '{default: 8'h00};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (b = 0; b < 48; b++) begin
      seed = lfsr(seed);
      wr(16'h0150 + 16'(b), seed);
    end
    for (b = 0; b < 48; b++) begin
      rd(16'h0150 + 16'(b), expByte(shadow[b/16][b%16], b%16, 1'b0));
    end
    for (b = 0; b < 11; b++) wr(setup[b][23:8], setup[b][7:0]);
    slow <= 1'b1;
    send(3'b000, 2'h1, {29'h52D, 1'b0, 1'b0, 1'b0, 4'h2}, 2);
    slow <= 1'b0;
    send(3'b110, 2'h0, extHdr, 0);
    // Equal priorities everywhere so the lowest index must win
    wr(16'h015D, 8'h03);
    send(3'b000, 2'h0, extHdr, 0);
    txArbitrate <= 1'b1;
    @(posedge clock);
    txArbitrate <= 1'b0;
    repeat (4) @(posedge clock);
    for (k = 0; k < 2; k++) begin
      rxWrite <= 1'b1;
      for (o = 0; o < 13; o++) begin
        seed = lfsr(seed);
        bg[o] = (o == 1) ? (seed & 8'hE7) : (o == 12) ? (k ? 8'h02 : 8'hF8) : seed;
        rxByte <= '{4'(o), bg[o]};
        @(posedge clock);
      end
      rxWrite <= 1'b0;
      rxCopy <= 1'b1;
      @(posedge clock);
      rxCopy <= 1'b0;
      for (o = 0; o < 13; o++) if (o < 6 || k == 0 || o == 12) fg[o] = bg[o];
    end
    testMode <= 1'b1;
    for (o = 0; o < 12; o++) rd(16'h0120 + 16'(o), bg[o]);
    testMode <= 1'b0;
    rd(16'h0120, 8'h00);
    rd(16'h0180, 8'h00);
    rd(16'h0108, 8'h00);
    for (o = 0; o < 16; o++) wr(16'h0140 + 16'(o), ~fg[o]);
    for (o = 0; o < 16; o++) rd(16'h0140 + 16'(o), expByte(fg[o], o, 1'b1));
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
    repeat (3) @(posedge clock);
    end_sim();
  end
endmodule
`default_nettype wire
